//--- tbes_map.svh
// constants for the text buffer edit sequencer
// Function
// - phase two sets push reset hold-off
// - phase two loads key char, cursor to memaddr
// - phases three/four write prefix from buffer
// - phase four sets push, memaddr addressing
// - phase four clears insert-two, memaddr plus one
// - phase five records end marker seen
// - late five: display to buffer, latch to display
// - cycle two writes buffer, clears hold-off
// - cycle two repeats both late transfers
// - cycle three: memaddr up, cursor plus two, stop
// - push done gives load complete, clears busy
// - pull edit shifts later text back one
// - first pull cycle writes key char over prefix
// - cursor pull cycle restores, loads display
// - memaddr pull cycle writes display until end
// - end: memaddr one past, cursor two past
// - keyboards locked until two display sequences
// - first display sequence suppresses save
// - next fetch reloads cursor plus one
// - second display sequence releases keyboards
// - strobe sets per-monitor load flag too
// - single slot over prefix starts pull edit
`ifndef TBES_MAP_SVH
`define TBES_MAP_SVH
`define TBES_REG_CURSOR 4'h0
`define TBES_REG_STATUS 4'h4
`define TBES_REG_MEMADDR 4'h8
`define TBES_END_MARKER 6'h3f
`define TBES_PREFIX_CODE 6'h3e
`define TBES_PH_IDLE 3'h0
`define TBES_PH_ONE 3'h1
`define TBES_PH_TWO 3'h2
`define TBES_PH_THREE 3'h3
`define TBES_PH_FOUR 3'h4
`define TBES_PH_FIVE 3'h5
`define TBES_PH_FIVE_LATE 3'h6
`define TBES_RST_ADDR 10'h000
`define TBES_RST_CHAR 6'h00
`define TBES_ST_BUSY 4
`define TBES_ST_HOLD 5
`define TBES_ST_PUSH 6
`define TBES_ST_DONE 7
`endif

//--- tbes_pkg.sv
// types for the text buffer edit sequencer
package tbes_pkg;
  typedef enum logic [3:0] {
    TBES_IDLE = 4'b0000,
    TBES_P2_CYC1 = 4'b0001,
    TBES_P2_CYC2 = 4'b0010,
    TBES_P2_CYC3 = 4'b0011,
    TBES_PL_FIRST = 4'b0100,
    TBES_PL_CUR = 4'b0101,
    TBES_PL_MEM = 4'b0110,
    TBES_FX_DISP1 = 4'b0111,
    TBES_FX_FETCH = 4'b1000,
    TBES_FX_DISP2 = 4'b1001
  } tbes_state_e;

  typedef struct packed {
    tbes_state_e st;
    logic [2:0] ph;
    logic [9:0] cur;
    logic [9:0] ma;
    logic [5:0] kch;
    logic [5:0] disp;
    logic [5:0] bufr;
    logic [5:0] rl;
    logic holdoff;
    logic end_seen;
    logic push;
    logic ins_two;
    logic rep_one;
    logic done;
    logic last;
    logic busy;
    logic hold;
    logic delete_next_flag;
    logic keyboard_load_complete;
    logic save_sup;
    logic [1:0] mon;
    logic [3:0] lpf;
    logic [3:0] ldf;
    logic mrd;
    logic mwr;
    logic [9:0] maddr;
    logic [5:0] mwd;
    logic [15:0] rdat;
  } tbes_state_s;
endpackage

//--- tbes_seq.sv
// memory cycle sequencer for push-by-two and pull-by-one replace edits
//
// Implementation choices: the register addresses and the plain strobed port.
`include "tbes_map.svh"
module tbes_seq (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic kb_strobe_in,
  input wire logic [5:0] kb_char_in,
  input wire logic kb_two_slot_in,
  input wire logic [1:0] kb_monitor_in,
  input wire logic cursor_over_end_in,
  input wire logic cursor_over_prefix_in,
  input wire logic [5:0] mem_rdata_in,
  input wire logic [3:0] display_done_in,
  input wire logic [3:0] fetch_seq_in,
  input wire logic [9:0] saved_cursor_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [9:0] mem_addr_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic [5:0] mem_wdata_out,
  output logic push_active_out,
  output logic kb_busy_out,
  output logic kb_load_complete_out,
  output logic kb_release_hold_out,
  output logic save_suppress_out,
  output logic [3:0] load_pending_out,
  output logic [3:0] per_monitor_load_out,
  output logic [15:0] reg_rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;

  tbes_pkg::tbes_state_s s_reg;
  tbes_pkg::tbes_state_s s_next;

  // address counters wrap inside the 1024 location core
  function automatic logic [9:0] bump(input logic [9:0] a, input logic [1:0] n);
    bump = a + {8'h00, n};
  endfunction

  // next-state logic: memory-cycle edits keyed on the current phase, idle and fixup states on strobe and sequence inputs
  always_comb begin
    s_next = s_reg;
    s_next.keyboard_load_complete = 1'b0;
    s_next.save_sup = 1'b0;

    // pending loads end with the display sequence of their monitor
    s_next.lpf = s_reg.lpf & ~display_done_in;
    // per-monitor load flag lives on only while the busy flag does
    if (!s_reg.busy) begin
      s_next.ldf = 4'h0;
    end

    // load complete frees the keyboards unless the release hold stands
    if (s_reg.keyboard_load_complete && !s_reg.hold) begin
      s_next.busy = 1'b0;
      s_next.done = 1'b0;
    end

    // software may park the cursor only while nothing is in flight
    if (reg_wr_in && reg_addr_in == `TBES_REG_CURSOR && s_reg.st == tbes_pkg::TBES_IDLE) begin
      s_next.cur = reg_wdata_in[9:0];
    end

    // the read latch catches the core output at the end of phase two
    if (s_reg.ph == `TBES_PH_TWO) begin
      s_next.rl = mem_rdata_in;
    end

    // the phase counter steps through one memory cycle, late five last
    if (s_reg.ph != `TBES_PH_IDLE) begin
      if (s_reg.ph == `TBES_PH_FIVE_LATE) begin
        s_next.ph = `TBES_PH_ONE;
      end else begin
        s_next.ph = s_reg.ph + 3'h1;
      end
    end

    case (s_reg.st)
      tbes_pkg::TBES_IDLE: begin
        if (kb_strobe_in && !s_reg.busy) begin
          // keyboard_strobe_allow: only a free unit takes a character
          s_next.busy = 1'b1;
          s_next.kch = kb_char_in;
          s_next.mon = kb_monitor_in;
          s_next.lpf[kb_monitor_in] = 1'b1;
          s_next.ldf[kb_monitor_in] = 1'b1;
          if (kb_two_slot_in && cursor_over_end_in) begin
            s_next.ins_two = 1'b1;
            s_next.st = tbes_pkg::TBES_P2_CYC1;
            s_next.ph = `TBES_PH_ONE;
          end else if (!kb_two_slot_in && cursor_over_prefix_in) begin
            s_next.rep_one = 1'b1;
            s_next.hold = 1'b1;
            s_next.delete_next_flag = 1'b1;
            s_next.st = tbes_pkg::TBES_PL_FIRST;
            s_next.ph = `TBES_PH_ONE;
          end else begin
            // other edits belong elsewhere; just hand the keyboard back
            s_next.keyboard_load_complete = 1'b1;
          end
        end
      end

      tbes_pkg::TBES_P2_CYC1: begin
        case (s_reg.ph)
          `TBES_PH_ONE: begin
            s_next.bufr = `TBES_PREFIX_CODE;
          end
          `TBES_PH_TWO: begin
            // hold-off keeps push from seeing set and reset at phase four
            s_next.holdoff = 1'b1;
            s_next.disp = s_reg.kch;
            s_next.ma = s_reg.cur;
          end
          `TBES_PH_FOUR: begin
            s_next.push = 1'b1;
            s_next.ins_two = 1'b0;
            s_next.ma = bump(s_reg.ma, 2'h1);
          end
          `TBES_PH_FIVE: begin
            s_next.end_seen = 1'b1;
          end
          `TBES_PH_FIVE_LATE: begin
            s_next.bufr = s_reg.disp;
            s_next.disp = s_reg.rl;
            s_next.st = tbes_pkg::TBES_P2_CYC2;
          end
          default: begin
          end
        endcase
      end

      tbes_pkg::TBES_P2_CYC2: begin
        case (s_reg.ph)
          `TBES_PH_FOUR: begin
            s_next.ma = bump(s_reg.ma, 2'h1);
          end
          `TBES_PH_FIVE: begin
            s_next.holdoff = 1'b0;
          end
          `TBES_PH_FIVE_LATE: begin
            // the read character is not needed, but loading it is harmless
            s_next.bufr = s_reg.disp;
            s_next.disp = s_reg.rl;
            s_next.st = tbes_pkg::TBES_P2_CYC3;
          end
          default: begin
          end
        endcase
      end

      tbes_pkg::TBES_P2_CYC3: begin
        if (s_reg.ph == `TBES_PH_FOUR) begin
          s_next.ma = bump(s_reg.ma, 2'h1);
          s_next.cur = bump(s_reg.cur, 2'h2);
          // a hold-off still set here would mean cycle two never reached phase five
          if (!s_reg.holdoff && s_reg.end_seen) begin
            // push reset stops cycles; late transfers never happen
            s_next.push = 1'b0;
            s_next.end_seen = 1'b0;
            s_next.ph = `TBES_PH_IDLE;
            s_next.st = tbes_pkg::TBES_IDLE;
            s_next.done = 1'b1;
            s_next.keyboard_load_complete = 1'b1;
          end
        end
      end

      tbes_pkg::TBES_PL_FIRST: begin
        case (s_reg.ph)
          `TBES_PH_ONE: begin
            s_next.disp = s_reg.kch;
          end
          `TBES_PH_FOUR: begin
            s_next.cur = bump(s_reg.cur, 2'h1);
          end
          `TBES_PH_FIVE: begin
            // both now point past the prefix; cursor moves one ahead next
            s_next.ma = s_reg.cur;
            s_next.delete_next_flag = 1'b0;
          end
          `TBES_PH_FIVE_LATE: begin
            s_next.cur = bump(s_reg.cur, 2'h1);
            s_next.rep_one = 1'b0;
            s_next.st = tbes_pkg::TBES_PL_CUR;
          end
          default: begin
          end
        endcase
      end

      tbes_pkg::TBES_PL_CUR: begin
        case (s_reg.ph)
          `TBES_PH_FOUR: begin
            s_next.cur = bump(s_reg.cur, 2'h1);
            if (s_reg.rl == `TBES_END_MARKER) begin
              s_next.last = 1'b1;
            end
          end
          `TBES_PH_FIVE_LATE: begin
            s_next.disp = s_reg.rl;
            s_next.st = tbes_pkg::TBES_PL_MEM;
          end
          default: begin
          end
        endcase
      end

      tbes_pkg::TBES_PL_MEM: begin
        case (s_reg.ph)
          `TBES_PH_FOUR: begin
            s_next.ma = bump(s_reg.ma, 2'h1);
          end
          `TBES_PH_FIVE_LATE: begin
            if (s_reg.last) begin
              // end marker has been moved; now repair the cursor
              s_next.last = 1'b0;
              s_next.ph = `TBES_PH_IDLE;
              s_next.st = tbes_pkg::TBES_FX_DISP1;
            end else begin
              s_next.st = tbes_pkg::TBES_PL_CUR;
            end
          end
          default: begin
          end
        endcase
      end

      tbes_pkg::TBES_FX_DISP1: begin
        // the stored cursor must not be replaced by the wrong address
        if (display_done_in[s_reg.mon]) begin
          s_next.save_sup = 1'b1;
          s_next.st = tbes_pkg::TBES_FX_FETCH;
        end
      end

      tbes_pkg::TBES_FX_FETCH: begin
        if (fetch_seq_in[s_reg.mon]) begin
          s_next.cur = bump(saved_cursor_in, 2'h1);
          s_next.st = tbes_pkg::TBES_FX_DISP2;
        end
      end

      tbes_pkg::TBES_FX_DISP2: begin
        if (display_done_in[s_reg.mon]) begin
          s_next.hold = 1'b0;
          s_next.busy = 1'b0;
          s_next.st = tbes_pkg::TBES_IDLE;
        end
      end

      default: begin
        s_next.st = tbes_pkg::TBES_IDLE;
        s_next.ph = `TBES_PH_IDLE;
      end
    endcase

    // core strobes: read in phases one and two, write in three and four
    s_next.mrd = (s_next.ph == `TBES_PH_ONE) || (s_next.ph == `TBES_PH_TWO);
    s_next.mwr = (s_next.ph == `TBES_PH_THREE) || (s_next.ph == `TBES_PH_FOUR);

    // memaddr_select while push is active or in a memaddr pull cycle
    if (s_next.push || s_next.st == tbes_pkg::TBES_PL_MEM) begin
      s_next.maddr = s_next.ma;
    end else begin
      s_next.maddr = s_next.cur;
    end

    // write source: buffer for push, latch for cursor pull, else display
    case (s_next.st)
      tbes_pkg::TBES_P2_CYC1,
      tbes_pkg::TBES_P2_CYC2,
      tbes_pkg::TBES_P2_CYC3: begin
        s_next.mwd = s_next.bufr;
      end
      tbes_pkg::TBES_PL_CUR: begin
        s_next.mwd = s_next.rl;
      end
      default: begin
        s_next.mwd = s_next.disp;
      end
    endcase
    if (!s_next.mwr) begin
      s_next.mwd = `TBES_RST_CHAR;
    end

    // register read data stands only in the cycle after the strobe
    s_next.rdat = 16'h0000;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `TBES_REG_CURSOR: begin
          s_next.rdat = {6'h00, s_reg.cur};
        end
        `TBES_REG_STATUS: begin
          // state code in the low nibble, flags above it, upper byte zero
          s_next.rdat[3:0] = s_reg.st;
          s_next.rdat[`TBES_ST_BUSY] = s_reg.busy;
          s_next.rdat[`TBES_ST_HOLD] = s_reg.hold;
          s_next.rdat[`TBES_ST_PUSH] = s_reg.push;
          s_next.rdat[`TBES_ST_DONE] = s_reg.done;
        end
        `TBES_REG_MEMADDR: begin
          s_next.rdat = {6'h00, s_reg.ma};
        end
        default: begin
          s_next.rdat = 16'h0000;
        end
      endcase
    end
  end

  // one register bank for all state; reset puts everything idle
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      s_reg <= '{st: tbes_pkg::TBES_IDLE, ph: `TBES_PH_IDLE,
                 cur: `TBES_RST_ADDR, ma: `TBES_RST_ADDR, maddr: `TBES_RST_ADDR,
                 kch: `TBES_RST_CHAR, disp: `TBES_RST_CHAR, bufr: `TBES_RST_CHAR,
                 rl: `TBES_RST_CHAR, mwd: `TBES_RST_CHAR,
                 mon: 2'h0, lpf: 4'h0, ldf: 4'h0, rdat: 16'h0000, default: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // every output is a field of the state register
  assign mem_addr_out = s_reg.maddr;
  assign mem_rd_out = s_reg.mrd;
  assign mem_wr_out = s_reg.mwr;
  assign mem_wdata_out = s_reg.mwd;
  assign push_active_out = s_reg.push;
  assign kb_busy_out = s_reg.busy;
  assign kb_load_complete_out = s_reg.keyboard_load_complete;
  assign kb_release_hold_out = s_reg.hold;
  assign save_suppress_out = s_reg.save_sup;
  assign load_pending_out = s_reg.lpf;
  assign per_monitor_load_out = s_reg.ldf;
  assign reg_rdata_out = s_reg.rdat;

endmodule

//--- tbes_seq_sva.sv
// port assertions for the edit sequencer
`include "tbes_map.svh"
module tbes_seq_sva (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic kb_strobe_in,
  input wire logic [9:0] mem_addr_out,
  input wire logic mem_rd_out,
  input wire logic mem_wr_out,
  input wire logic [5:0] mem_wdata_out,
  input wire logic push_active_out,
  input wire logic kb_busy_out,
  input wire logic kb_load_complete_out,
  input wire logic kb_release_hold_out,
  input wire logic save_suppress_out,
  input wire logic [3:0] load_pending_out,
  input wire logic [3:0] per_monitor_load_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  // core cycle: two read clocks, then two write clocks at one address
  property p_rd_len; $rose(mem_rd_out) |=> mem_rd_out ##1 !mem_rd_out; endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe length");
  property p_wr_follow; $fell(mem_rd_out) |-> mem_wr_out [*2] ##1 !mem_wr_out; endproperty
  a_wr_follow: assert property (p_wr_follow) else $error("write after read");
  property p_addr_hold; $fell(mem_rd_out) |-> $stable(mem_addr_out) ##1 $stable(mem_addr_out); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in cycle");
  // push flag rises just after the prefix write and drops twelve clocks later
  property p_prefix; $rose(push_active_out) |-> $past(mem_wdata_out) == `TBES_PREFIX_CODE; endproperty
  a_prefix: assert property (p_prefix) else $error("push without prefix write");
  property p_push_len;
    $rose(push_active_out) |-> ##11 push_active_out ##1 (!push_active_out && kb_load_complete_out);
  endproperty
  a_push_len: assert property (p_push_len) else $error("push length");
  property p_done_busy; kb_load_complete_out && !kb_release_hold_out |=> !kb_busy_out; endproperty
  a_done_busy: assert property (p_done_busy) else $error("busy kept after load complete");
  property p_strobe;
    kb_strobe_in && !kb_busy_out |=> kb_busy_out && (per_monitor_load_out & load_pending_out) != 4'h0;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe not taken");
  property p_hold; kb_release_hold_out |-> kb_busy_out; endproperty
  a_hold: assert property (p_hold) else $error("hold without busy");
  property p_save; save_suppress_out |-> kb_release_hold_out ##1 !save_suppress_out; endproperty
  a_save: assert property (p_save) else $error("save suppress");
  // a strobe taken in the very cycle busy drops sets a fresh flag, and the set wins
  property p_pml; $fell(kb_busy_out) && !kb_strobe_in |=> per_monitor_load_out == 4'h0; endproperty
  a_pml: assert property (p_pml) else $error("load flag kept");
  c_push: cover property ($rose(push_active_out));
  c_save: cover property (save_suppress_out);
  c_hold: cover property ($fell(kb_release_hold_out));
endmodule
bind tbes_seq tbes_seq_sva tbes_seq_sva_i (.sys_clk_in, .sys_rst_in, .kb_strobe_in, .mem_addr_out, .mem_rd_out,
  .mem_wr_out, .mem_wdata_out, .push_active_out, .kb_busy_out, .kb_load_complete_out, .kb_release_hold_out,
  .save_suppress_out, .load_pending_out, .per_monitor_load_out);

//--- tbes_mem_model.sv
// core memory model for the sequencer's memory port
module tbes_mem_model (
  input wire logic sys_clk_in,
  input wire logic [9:0] mem_addr_in,
  input wire logic mem_rd_in,
  input wire logic mem_wr_in,
  input wire logic [5:0] mem_wdata_in,
  output logic [5:0] mem_rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] mem [1024];
  logic [5:0] last = 6'h2a;
  // released read lines show the inverse of the last word, so a late sample is caught
  assign mem_rdata_out = mem_rd_in ? mem[mem_addr_in] : ~last;
  // read in phases one and two, write in three and four
  // plain always: the bench preloads the array directly before the push and pull scenarios
  always @(posedge sys_clk_in) begin
    if (mem_wr_in) begin
      mem[mem_addr_in] <= mem_wdata_in;
    end
    if (mem_rd_in) begin
      last <= mem[mem_addr_in];
    end
  end
endmodule

//--- tb_text_buffer_edit_sequencer.sv
// self-checking bench for the edit sequencer
`include "tbes_map.svh"
module tb_text_buffer_edit_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = '0, rst = '1, stb = '0, two = '0, ovend = '0, ovpre = '0, wr = '0, rd = '0;
  logic [5:0] kch = '0, rdat, mwd;
  logic [1:0] mon = '0;
  logic [3:0] dd = '0, fs = '0, ra = '0, lp, pml;
  logic [9:0] sav = '0, ma;
  logic [15:0] wd = '0, rdo, v;
  logic mrd, mwr, pa, busy, keyboard_load_complete, hold, sup;
  int mismatches = 0, checks_done = 0, cyc = 0;
  tbes_seq tbes_seq_i (.sys_clk_in(clk), .sys_rst_in(rst), .kb_strobe_in(stb), .kb_char_in(kch),
    .kb_two_slot_in(two), .kb_monitor_in(mon), .cursor_over_end_in(ovend), .cursor_over_prefix_in(ovpre),
    .mem_rdata_in(rdat), .display_done_in(dd), .fetch_seq_in(fs), .saved_cursor_in(sav), .reg_addr_in(ra),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .mem_addr_out(ma), .mem_rd_out(mrd), .mem_wr_out(mwr),
    .mem_wdata_out(mwd), .push_active_out(pa), .kb_busy_out(busy), .kb_load_complete_out(keyboard_load_complete),
    .kb_release_hold_out(hold), .save_suppress_out(sup), .load_pending_out(lp), .per_monitor_load_out(pml),
    .reg_rdata_out(rdo));
  tbes_mem_model tbes_mem_model_i (.sys_clk_in(clk), .mem_addr_in(ma), .mem_rd_in(mrd), .mem_wr_in(mwr),
    .mem_wdata_in(mwd), .mem_rdata_out(rdat));
  // clock and a hang limit far above the roughly 120 cycles needed
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic test_done;
    if (mismatches == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  // read data stand only in the cycle after the read edge
  task automatic reg_rd(logic [3:0] a);
    @(posedge clk);
    ra <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 v = rdo;
  endtask
  task automatic key(logic [5:0] c, logic t, logic e, logic p, logic [1:0] m);
    @(posedge clk);
    kch <= c;
    two <= t;
    ovend <= e;
    ovpre <= p;
    mon <= m;
    stb <= 1'h1;
    @(posedge clk);
    stb <= 1'h0;
    #1;
  endtask
  task automatic seq_pulse(logic f, logic [3:0] b);
    @(posedge clk);
    sav <= 10'h200;
    if (f) fs <= b;
    else dd <= b;
    @(posedge clk);
    fs <= 4'h0;
    dd <= 4'h0;
  endtask
  // the pull edit has no done flag, so wait for the memory port to fall quiet
  task automatic wait_idle;
    int q;
    q = 0;
    for (int i = 0; i < 200 && q < 8; i++) begin
      @(posedge clk);
      q = (mrd || mwr) ? 0 : q + 1;
    end
  endtask
  task automatic t_push;
    tbes_mem_model_i.mem[10'h100] = `TBES_END_MARKER;
    reg_wr(4'h0, 16'h0100);
    key(6'h15, 1'h1, 1'h1, 1'h0, 2'h0);
    repeat (5) @(posedge clk);
    #1 chk("push", 16'(pa), 16'h0001);
    for (int i = 0; i < 40 && keyboard_load_complete !== 1'h1; i++) begin
      @(posedge clk);
      #1;
    end
    chk("push", 16'(pa), 16'h0000);
    @(posedge clk);
    #1 chk("busy", 16'(busy), 16'h0000);
    chk("m100", 16'(tbes_mem_model_i.mem[10'h100]), 16'h003e);
    chk("m101", 16'(tbes_mem_model_i.mem[10'h101]), 16'h0015);
    chk("m102", 16'(tbes_mem_model_i.mem[10'h102]), 16'h003f);
    reg_rd(4'h0);
    chk("cursor", v, 16'h0102);
    reg_rd(4'h8);
    chk("memaddr", v, 16'h0103);
    chk("pml", 16'(pml), 16'h0000);
    reg_rd(4'hc);
    chk("unmapped", v, 16'h0000);
  endtask
  task automatic t_neither;
    key(6'h05, 1'h1, 1'h0, 1'h0, 2'h1);
    chk("keyboard_load_complete", 16'(keyboard_load_complete), 16'h0001);
    @(posedge clk);
    #1 chk("busy", 16'(busy), 16'h0000);
  endtask
  task automatic t_pull;
    tbes_mem_model_i.mem[10'h200] = `TBES_PREFIX_CODE;
    tbes_mem_model_i.mem[10'h201] = 6'h2b;
    tbes_mem_model_i.mem[10'h202] = 6'h11;
    tbes_mem_model_i.mem[10'h203] = 6'h12;
    tbes_mem_model_i.mem[10'h204] = `TBES_END_MARKER;
    reg_wr(4'h0, 16'h0200);
    key(6'h0b, 1'h0, 1'h0, 1'h1, 2'h2);
    chk("hold", 16'(hold), 16'h0001);
    chk("pml", 16'(pml & lp), 16'h0004);
    wait_idle();
    chk("m200", 16'(tbes_mem_model_i.mem[10'h200]), 16'h000b);
    chk("m201", 16'(tbes_mem_model_i.mem[10'h201]), 16'h0011);
    chk("m202", 16'(tbes_mem_model_i.mem[10'h202]), 16'h0012);
    chk("m203", 16'(tbes_mem_model_i.mem[10'h203]), 16'h003f);
    chk("m204", 16'(tbes_mem_model_i.mem[10'h204]), 16'h003f);
    reg_rd(4'h8);
    chk("memaddr", v, 16'h0204);
    reg_rd(4'h0);
    chk("cursor", v, 16'h0205);
    reg_rd(4'h4);
    chk("status", v, 16'h0037);
    key(6'h01, 1'h1, 1'h1, 1'h0, 2'h0);
    chk("locked", 16'(mrd), 16'h0000);
    repeat (3) @(posedge clk);
    seq_pulse(1'h0, 4'h4);
    #1 chk("suppress", 16'(sup), 16'h0001);
    chk("pending", 16'(lp), 16'h0003);
    seq_pulse(1'h1, 4'h4);
    reg_rd(4'h0);
    chk("fixed", v, 16'h0201);
    chk("busy", 16'(busy), 16'h0001);
    seq_pulse(1'h0, 4'h4);
    #1 chk("busy", 16'(busy), 16'h0000);
    chk("hold", 16'(hold), 16'h0000);
  endtask
  initial begin
    foreach (tbes_mem_model_i.mem[i]) tbes_mem_model_i.mem[i] = 6'h00;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    t_push();
    t_neither();
    t_pull();
    repeat (4) @(posedge clk);
    test_done();
  end
endmodule
